// >>> shared/spi_port_pkg.sv
package spi_port_pkg;

	// Frame lengths in serial clock falling edges
	localparam logic [5:0] FRAME_LEN_CHECKED = 6'h20;
	localparam logic [5:0] FRAME_LEN_PLAIN   = 6'h18;

	// Command word layout (24 bits, check byte excluded)
	localparam int CMD_W      = 24;
	localparam int RW_POS     = 23;
	localparam int ADDR_MSB   = 22;
	localparam int ADDR_LSB   = 16;
	localparam int DATA_MSB   = 15;
	localparam int ADDR_W     = 7;
	localparam int DATA_W     = 16;
	localparam int STATUS_W   = 6;
	localparam int CRC_W      = 8;
	localparam int SHIFT_W    = 32;

	// Position where the delayed input is fed into the output shifter
	localparam logic [4:0] FEED_POS_CHECKED = 5'h00;
	localparam logic [4:0] FEED_POS_PLAIN   = 5'h08;

	// Check polynomial x^8+x^2+x+1 without the implicit top term
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// Address that carries no register (no-operation frame)
	localparam logic [6:0] NOP_ADDR = 7'h00;
	// Address of the break-mode register; value is arbitrary
	localparam logic [6:0] BREAK_REG_ADDR = 7'h7E;

	// Reset values of the frame-held configuration copies
	localparam logic RST_CHECK_EN    = 1'b1;
	localparam logic RST_OUT_DISABLE = 1'b1;
	localparam logic RST_FALL_SEL    = 1'b0;

	// Timing: fastest serial clock against the system clock
	localparam int SYS_CLK_HZ       = 100_000_000;
	localparam int SCLK_MAX_HZ      = 12_500_000;
	localparam int SCLK_MIN_SYS_CYC = SYS_CLK_HZ / SCLK_MAX_HZ;
	localparam int SYNC_STAGES      = 2;

	// Eight-bit frame check over a 24-bit word, most significant bit first
	function automatic logic [7:0] crc8(input logic [23:0] data);
		logic [7:0] crc;
		logic       fb;
		crc = CRC_INIT;
		fb  = 1'b0;
		for (int i = CMD_W - 1; i >= 0; i--) begin
			fb  = crc[7] ^ data[i];
			crc = {crc[6:0], 1'b0};
			if (fb) begin
				crc = crc ^ CRC_POLY;
			end
		end
		return crc;
	endfunction

endpackage

// >>> src/pin_sync.sv
// Two-flop synchroniser for pins arriving from outside the system clock
module pin_sync #(
	parameter int          WIDTH     = 1,
	parameter logic [31:0] RESET_VAL = 32'h0
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Asynchronous pins and their synchronised copies
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	// First stage is read by the second stage only
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] q_r;

	// Both stages reset to the idle level of the pins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= RESET_VAL[WIDTH-1:0];
			q_r    <= RESET_VAL[WIDTH-1:0];
		end else begin
			meta_r <= d_in;
			q_r    <= meta_r;
		end
	end

	assign q_out = q_r;

endmodule

// >>> src/spi_register_access_port.sv
// Behaviour
// - Supports clock modes one and two
// - Free-running or gated serial clock both accepted
// - First and last bits on falling edges
// - Checked frame: flag, address, data, check byte
// - Checking on after reset; off gives 24 bits
// - Short frame discarded, registers untouched
// - Long frame: only newest frame-length bits count
// - Frame executed when chip select rises
// - Deselected: clock and input ignored, output released
// - Input sampled on falling edges, right-justified
// - Extra edges echo input delayed one frame
// - Read flag requests data for next frame
// - Read data returned next frame, MSB first
// - Write answers status and zero data next frame
// - Output driven only when selected and enabled
// - First bit at select; later on chosen edge
// - Output starts with previous flag, seven status
// - Check-error status reflects previous input frame
// - Break-mode register unreachable from this port
// - Ignored read data bits enter the check
// - Check byte uses x^8+x^2+x+1 over 24 bits
// - Failed check: no command, check_error_out pulsed
// - Frame handed to system clock after select rises
module spi_register_access_port (
	// System clock and reset
	input  wire logic                                sys_clk_in,
	input  wire logic                                rst_n_in,
	// Serial pins from the host
	input  wire logic                                sclk_in,
	input  wire logic                                cs_n_in,
	input  wire logic                                sdi_in,
	// Serial output pin, split into level and enable
	output logic                                     sdo_out,
	output logic                                     sdo_oe_out,
	// Configuration bits from the register map
	input  wire logic                                check_enable_in,
	input  wire logic                                serial_output_disable_in,
	input  wire logic                                output_falling_edge_select_in,
	// Status bits shown in each output frame
	input  wire logic [spi_port_pkg::STATUS_W-1:0]   status_in,
	// Register map access
	output logic      [spi_port_pkg::ADDR_W-1:0]     reg_addr_out,
	output logic      [spi_port_pkg::DATA_W-1:0]     reg_wdata_out,
	output logic                                     reg_wr_out,
	output logic                                     reg_rd_out,
	input  wire logic [spi_port_pkg::DATA_W-1:0]     reg_rdata_in,
	// One pulse per frame that failed its check
	output logic                                     check_error_out
);

	// Response builder state: waiting, strobe out, or fetching read data
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_FETCH
	} resp_state_t;

	// Synchronised pins
	logic                                  sclk_s;
	logic                                  cs_n_s;
	logic                                  sdi_s;
	// Previous synchronised levels for edge finding
	logic                                  sclk_d_r;
	logic                                  cs_n_d_r;
	// Frame-held configuration copies
	logic                                  check_en_r;
	logic                                  out_dis_r;
	logic                                  fall_sel_r;
	// Receive shifter and falling edge count
	logic [spi_port_pkg::SHIFT_W-1:0]      rx_r;
	logic [5:0]                            cnt_r;
	logic [5:0]                            cnt_nxt;
	// Transmit shifter and output enable
	logic [spi_port_pkg::SHIFT_W-1:0]      tx_r;
	logic [spi_port_pkg::SHIFT_W-1:0]      tx_nxt;
	logic                                  sdo_oe_r;
	// Response held for the next frame
	logic                                  resp_rw_r;
	logic                                  crc_err_r;
	logic [spi_port_pkg::DATA_W-1:0]       resp_data_r;
	resp_state_t                           state_r;
	// Register access strobes and fields
	logic [spi_port_pkg::ADDR_W-1:0]       addr_r;
	logic [spi_port_pkg::DATA_W-1:0]       wdata_r;
	logic                                  wr_r;
	logic                                  rd_r;
	logic                                  chk_err_r;

	// All three pins cross from the host's timing; idle is select high
	pin_sync #(
		.WIDTH     (3),
		.RESET_VAL (32'h2)
	) u_pin_sync (
		.clk_in   (sys_clk_in),
		.rst_n_in (rst_n_in),
		.d_in     ({sclk_in, cs_n_in, sdi_in}),
		.q_out    ({sclk_s, cs_n_s, sdi_s})
	);

	// Edge finding on the synchronised pins; sampling suits any clock
	// pattern, free-running or gated, since only edges are used
	wire cs_active = ~cs_n_s;
	wire sclk_fall = cs_active & sclk_d_r & ~sclk_s;
	wire sclk_rise = cs_active & ~sclk_d_r & sclk_s;
	wire cs_fall   = cs_n_d_r & ~cs_n_s;
	wire cs_rise   = ~cs_n_d_r & cs_n_s;

	// Frame length follows the check setting
	wire [5:0] frame_len = check_en_r ? spi_port_pkg::FRAME_LEN_CHECKED
	                                  : spi_port_pkg::FRAME_LEN_PLAIN;

	// In mode one the first edge is rising and carries no new bit, so a
	// rising launch waits until one bit has been taken
	wire launch_rise = sclk_rise & (cnt_r != 6'h00);
	wire launch      = fall_sel_r ? sclk_fall : launch_rise;

	// Newest input bit; on a falling launch it is the one being taken now
	wire echo_bit = fall_sel_r ? sdi_s : rx_r[0];
	// Feed point so that echoed input trails by exactly one frame
	wire [4:0] feed_pos = check_en_r ? spi_port_pkg::FEED_POS_CHECKED
	                                 : spi_port_pkg::FEED_POS_PLAIN;

	// Received command: the newest bits are the frame
	wire [spi_port_pkg::CMD_W-1:0] rx_cmd =
		check_en_r ? rx_r[31:8] : rx_r[23:0];
	wire [7:0] rx_crc   = rx_r[7:0];
	// Read frames keep their ignored data bits inside the check
	wire       crc_ok   = ~check_en_r
	                    | (spi_port_pkg::crc8(rx_cmd) == rx_crc);
	wire       full     = cnt_r >= frame_len;
	wire       rx_rw    = rx_cmd[spi_port_pkg::RW_POS];
	wire [spi_port_pkg::ADDR_W-1:0] rx_addr =
		rx_cmd[spi_port_pkg::ADDR_MSB:spi_port_pkg::ADDR_LSB];
	wire [spi_port_pkg::DATA_W-1:0] rx_data =
		rx_cmd[spi_port_pkg::DATA_MSB:0];
	// The break-mode register belongs to the UART path alone
	wire       addr_ok  = rx_addr != spi_port_pkg::BREAK_REG_ADDR;
	wire       frame_go = cs_rise & full;
	wire       exec_ok  = frame_go & crc_ok;

	// Output frame: previous flag, check error, status, data, check byte
	wire [spi_port_pkg::CMD_W-1:0] tx_hi =
		{resp_rw_r, crc_err_r, status_in, resp_data_r};
	wire [spi_port_pkg::SHIFT_W-1:0] tx_load =
		check_en_r ? {tx_hi, spi_port_pkg::crc8(tx_hi)}
		           : {tx_hi, 8'h00};

	// Edge count restarts at select and saturates at the checked frame length of 32
	always_comb begin
		cnt_nxt = cnt_r;
		if (cs_fall) begin
			cnt_nxt = 6'h00;
		end else if (sclk_fall && cnt_r < spi_port_pkg::FRAME_LEN_CHECKED) begin
			cnt_nxt = cnt_r + 6'h01;
		end
	end

	// Transmit shifter: load at select, shift on the launch edge and feed
	// the delayed input in behind the frame
	always_comb begin
		tx_nxt = tx_r;
		if (cs_fall) begin
			tx_nxt = tx_load;
		end else if (launch) begin
			tx_nxt           = {tx_r[30:0], 1'b0};
			tx_nxt[feed_pos] = echo_bit;
		end
	end

	// Previous pin levels for the edge finders
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_d_r <= 1'b0;
			cs_n_d_r <= 1'b1;
		end else begin
			sclk_d_r <= sclk_s;
			cs_n_d_r <= cs_n_s;
		end
	end

	// Configuration is only taken between frames, so a change never
	// alters the length or launch edge of a frame in flight
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			check_en_r <= spi_port_pkg::RST_CHECK_EN;
			out_dis_r  <= spi_port_pkg::RST_OUT_DISABLE;
			fall_sel_r <= spi_port_pkg::RST_FALL_SEL;
		end else if (cs_n_s && cs_n_d_r) begin
			check_en_r <= check_enable_in;
			out_dis_r  <= serial_output_disable_in;
			fall_sel_r <= output_falling_edge_select_in;
		end
	end

	// Receive shifter takes input only on selected falling edges
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_r <= '0;
		end else if (sclk_fall) begin
			rx_r <= {rx_r[30:0], sdi_s};
		end
	end

	// Edge counter
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 6'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Transmit shifter and enable; the enable drops with select so the
	// line is released whenever the host deselects
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_r     <= '0;
			sdo_oe_r <= 1'b0;
		end else begin
			tx_r     <= tx_nxt;
			sdo_oe_r <= cs_active & ~out_dis_r;
		end
	end

	// Frame execution on the rising select edge. A short frame leaves
	// everything as it was, including the response queued for next time
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			resp_rw_r   <= 1'b0;
			crc_err_r   <= 1'b0;
			resp_data_r <= '0;
			state_r     <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (frame_go) begin
						resp_rw_r   <= rx_rw;
						crc_err_r   <= ~crc_ok;
						resp_data_r <= '0;
						// Reads fetch data one cycle after the strobe
						if (exec_ok && rx_rw && addr_ok) begin
							state_r <= ST_WAIT;
						end
					end
				end
				// Strobe is on the port now; the map answers next cycle
				ST_WAIT: begin
					state_r <= ST_FETCH;
				end
				ST_FETCH: begin
					resp_data_r <= reg_rdata_in;
					state_r     <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Register strobes: one system cycle each, a few cycles after the
	// select rises, which is the handover into the system clock
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_r    <= '0;
			wdata_r   <= '0;
			wr_r      <= 1'b0;
			rd_r      <= 1'b0;
			chk_err_r <= 1'b0;
		end else begin
			wr_r      <= 1'b0;
			rd_r      <= 1'b0;
			chk_err_r <= frame_go & ~crc_ok;
			if (exec_ok && addr_ok) begin
				addr_r <= rx_addr;
				// Write data is ignored by reads but kept on the port
				wdata_r <= rx_data;
				rd_r    <= rx_rw;
				// The no-operation frame writes nothing
				wr_r    <= ~rx_rw & (rx_addr != spi_port_pkg::NOP_ADDR);
			end
		end
	end

	// Outputs straight from flip-flops
	assign sdo_out         = tx_r[spi_port_pkg::SHIFT_W-1];
	assign sdo_oe_out      = sdo_oe_r;
	assign reg_addr_out    = addr_r;
	assign reg_wdata_out   = wdata_r;
	assign reg_wr_out      = wr_r;
	assign reg_rd_out      = rd_r;
	assign check_error_out = chk_err_r;

endmodule

// >>> test/spi_register_access_port_assertions.sv
module spi_register_access_port_assertions (
	// Clock and reset
	input wire logic       sys_clk_in,
	input wire logic       rst_n_in,
	// Select, output enable and its configuration bit
	input wire logic       cs_n_in,
	input wire logic       serial_output_disable_in,
	input wire logic       sdo_oe_out,
	// Register side
	input wire logic [6:0] reg_addr_out,
	input wire logic       reg_wr_out,
	input wire logic       reg_rd_out,
	input wire logic       check_error_out
);
	default clocking main_cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// A full frame that gave a write or read strobe or failed its check
	wire logic frame_done = reg_wr_out | reg_rd_out | check_error_out;

	AST_OE_OFF_DESELECTED: assert property (cs_n_in [*5] |-> !sdo_oe_out)
		else $error("Output enabled while deselected");
	AST_OE_NEEDS_SELECT: assert property ($rose(sdo_oe_out) |-> !$past(cs_n_in, 2))
		else $error("Output enabled without select");
	AST_OE_NOT_DISABLED: assert property ($rose(sdo_oe_out) |-> !serial_output_disable_in)
		else $error("Output enabled while disabled");
	// Config is held steady by the bench around frames, so a long select must drive
	AST_OE_FOLLOWS_SELECT: assert property (
		(!cs_n_in && !serial_output_disable_in) [*6] |-> sdo_oe_out)
		else $error("Output not driven in a selected frame");
	AST_OE_DROPS_AFTER_RISE: assert property ($fell(sdo_oe_out) |-> $past(cs_n_in, 2))
		else $error("Output released while selected");
	AST_EXEC_ON_SELECT_RISE: assert property (frame_done |-> $past(cs_n_in, 2) && cs_n_in)
		else $error("Frame outcome before select rose");
	AST_ONE_OUTCOME: assert property ($onehot0({reg_wr_out, reg_rd_out, check_error_out}))
		else $error("Several frame outcomes at once");
	AST_SINGLE_PULSE: assert property (frame_done |=> !frame_done [*3])
		else $error("Frame outcome repeated");
	AST_NO_BREAK_ACCESS: assert property (
		(reg_wr_out || reg_rd_out) |-> reg_addr_out != spi_port_pkg::BREAK_REG_ADDR)
		else $error("Break register reached");
endmodule

bind spi_register_access_port spi_register_access_port_assertions assert_i (
	.sys_clk_in(sys_clk_in),
	.rst_n_in(rst_n_in),
	.cs_n_in(cs_n_in),
	.serial_output_disable_in(serial_output_disable_in),
	.sdo_oe_out(sdo_oe_out),
	.reg_addr_out(reg_addr_out),
	.reg_wr_out(reg_wr_out),
	.reg_rd_out(reg_rd_out),
	.check_error_out(check_error_out)
);

// >>> test/spi_host_model.sv
module spi_host_model (
	// System clock paces every serial edge
	input  wire logic sys_clk_in,
	// Serial pins toward the port
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      sdi_out,
	input  wire logic sdo_in,
	input  wire logic sdo_oe_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       idle_hi  = 1'b0;  // Clock idles high in mode 2
	logic       free_run = 1'b0;  // Clock keeps running between frames
	logic       busy     = 1'b0;  // A frame is in progress
	logic [2:0] gap_cnt  = 3'h0;  // Paces the free-running clock
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out  = 1'b0;
	end
	// Released data line floats: show a changing level rather than the last bit
	always @(posedge sys_clk_in) begin
		if (!busy) begin
			sdi_out <= ~sdi_out;
			gap_cnt <= gap_cnt + 3'h1;
			if (free_run && gap_cnt == 3'h7) begin
				sclk_out <= ~sclk_out;
			end
		end
	end
	// One frame of n bits, most significant first; output taken at each falling edge
	task automatic xfer(input logic [39:0] w, input int n, output logic [39:0] rx);
		rx = '0;
		@(negedge sys_clk_in);
		busy = 1'b1;
		@(posedge sys_clk_in);
		sclk_out <= idle_hi;
		repeat (8) @(posedge sys_clk_in);
		cs_n_out <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			repeat (8) @(posedge sys_clk_in);
			sclk_out <= 1'b1;
			sdi_out  <= w[i];
			repeat (8) @(posedge sys_clk_in);
			sclk_out <= 1'b0;
			rx = {rx[38:0], sdo_oe_in ? sdo_in : 1'bz};
		end
		repeat (8) @(posedge sys_clk_in);
		cs_n_out <= 1'b1;
		sclk_out <= idle_hi;
		@(negedge sys_clk_in);
		busy = 1'b0;
	endtask
endmodule

// >>> test/spi_register_access_port_tb.sv
module spi_register_access_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Compare two values; count the check and any mismatch
	`define CHK(n, e, g) begin \
		checked++; \
		if ((g) !== (e)) begin \
			err_total++; \
			$display("FAIL %s expected %0h seen %0h", n, e, g); \
		end \
	end
	// One ordinary frame and what it should give
	typedef struct {
		logic [23:0] cmd;   // Command word
		logic        mode;  // Clock idles high
		logic        fall;  // Later output bits on falling edge
		logic        wr;    // Write strobe expected
		logic        rd;    // Read strobe expected
		logic [15:0] resp;  // Response data in the next frame
	} row_t;
	row_t rows [5] = '{
		'{24'h05_1234, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000},  // Write
		'{24'h85_FFFF, 1'b1, 1'b0, 1'b0, 1'b1, 16'h1234},  // Read back, data ignored
		'{24'hFE_0000, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000},  // Break register: no access
		'{24'h00_4321, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000},  // Write to no-op address
		'{24'h85_0000, 1'b0, 1'b1, 1'b0, 1'b1, 16'h1234}   // Read again
	};
	// Pins, configuration and register side
	logic        clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, wr, rd, cerr;
	logic        check_en, out_dis, fall_sel;
	logic [5:0]  st;
	logic [6:0]  addr, wa;
	logic [15:0] wdata, wd, rdata;
	logic [15:0] mem [128];
	// Bookkeeping: strobe counts, received bits, expected word
	logic [7:0]  wr_n, rd_n, er_n, wr0, rd0, er0;
	logic [39:0] rx;
	logic [31:0] e;
	int          err_total, checked;
	// 100 MHz system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	spi_register_access_port DUT (
		.sys_clk_in(clk), .rst_n_in(rst_n),
		.sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
		.check_enable_in(check_en), .serial_output_disable_in(out_dis),
		.output_falling_edge_select_in(fall_sel), .status_in(st),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_rdata_in(rdata), .check_error_out(cerr)
	);
	spi_host_model HOST (
		.sys_clk_in(clk), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
		.sdo_in(sdo), .sdo_oe_in(sdo_oe)
	);
	// Register map stand-in: stores writes, answers a read the cycle after
	always @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
			wr_n  <= 8'h00;
			rd_n  <= 8'h00;
			er_n  <= 8'h00;
		end else begin
			if (wr) begin
				mem[addr] <= wdata;
				{wa, wd}  <= {addr, wdata};
			end
			rdata <= mem[addr];
			wr_n  <= wr_n + {7'h00, wr};
			rd_n  <= rd_n + {7'h00, rd};
			er_n  <= er_n + {7'h00, cerr};
		end
	end
	function automatic logic [7:0] crc_f(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction
	// Checked input frame: command then its check byte
	function automatic logic [39:0] fr(input logic [23:0] c);
		return {8'h00, c, crc_f(c)};
	endfunction
	// Expected output frame: flag, check error, status, data, check byte
	function automatic logic [31:0] resp(input logic rw, er, input logic [5:0] s,
		input logic [15:0] d);
		return {rw, er, s, d, crc_f({rw, er, s, d})};
	endfunction
	// Send one frame and let its outcome land
	task automatic send(input logic [39:0] w, input int n);
		wr0 = wr_n;
		rd0 = rd_n;
		er0 = er_n;
		HOST.xfer(w, n, rx);
		repeat (8) @(posedge clk);
	endtask
	task automatic results();
		$display("Checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A hang counts as a mismatch
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		$display("FAIL watchdog expected finish seen hang");
		results();
	end
	initial begin
		{rst_n, check_en, out_dis, fall_sel} = 4'h4;
		st = 6'h00;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("idle_outputs", 4'h0, {sdo_oe, wr, rd, cerr})
		$display("Test reset done");
		// Table: both clock modes, both launch edges, every command kind
		for (int i = 0; i <= 5; i++) begin
			@(posedge clk);
			st <= 6'h15 ^ 6'(i);
			HOST.idle_hi <= rows[i % 5].mode;
			fall_sel <= rows[i % 5].fall;
			send(fr(i < 5 ? rows[i % 5].cmd : 24'h000000), 32);
			if (i > 0) begin
				e = resp(rows[i - 1].cmd[23], 1'b0, st, rows[i - 1].resp);
				`CHK("response", e, rx[31:0])
			end
			if (i < 5) begin
				e = {16'h0000, 8'(rows[i].wr), 8'(rows[i].rd)};
				`CHK("strobes", e[15:0], {wr_n - wr0, rd_n - rd0})
			end
		end
		`CHK("write_word", 23'h05_1234, {wa, wd})
		$display("Test table done");
		// Corrupted check byte: nothing executed, error flagged next frame
		fall_sel <= 1'b0;
		send(fr(24'h06_BEEF) ^ 40'h01, 32);
		`CHK("bad_frame", 16'h0100, {er_n - er0, wr_n - wr0})
		send(fr(24'h000000), 32);
		`CHK("err_status", resp(1'b0, 1'b1, st, 16'h0000), rx[31:0])
		$display("Test check_error done");
		// Short frame dropped; long frame keeps its newest bits and echoes its oldest
		send(fr(24'h06_1111), 20);
		`CHK("short_frame", 16'h0000, {er_n - er0, wr_n - wr0})
		send(fr(24'h07_ABCD) | 40'h02_0000_0000, 34);
		`CHK("after_short", resp(1'b0, 1'b0, st, 16'h0000), rx[33:2])
		`CHK("echo", 2'b10, rx[1:0])
		`CHK("long_frame", 23'h07_ABCD, {wa, wd})
		$display("Test frame_length done");
		// Checking off: 24-bit frames with no check byte
		check_en <= 1'b0;
		send({16'h0000, 24'h08_5A5A}, 24);
		`CHK("plain_write", 23'h08_5A5A, {wa, wd})
		send(40'h00_0000_0000, 24);
		`CHK("plain_resp", {2'b00, st, 16'h0000}, rx[23:0])
		check_en <= 1'b1;
		$display("Test no_check done");
		// Output disabled, then a clock that keeps running between frames
		out_dis <= 1'b1;
		HOST.free_run <= 1'b1;
		send(fr(24'h000000), 32);
		`CHK("released", {32{1'bz}}, rx[31:0])
		out_dis <= 1'b0;
		repeat (40) @(posedge clk);
		send(fr(24'h000000), 32);
		`CHK("free_clock", resp(1'b0, 1'b0, st, 16'h0000), rx[31:0])
		HOST.free_run <= 1'b0;
		$display("Test output_enable done");
		// Reset in mid-run clears the outputs at once
		rst_n <= 1'b0;
		@(posedge clk);
		`CHK("reset_again", 4'h0, {sdo_oe, wr, rd, cerr})
		rst_n <= 1'b1;
		// After reset the queued response is empty and frames still run
		send(fr(24'h000000), 32);
		`CHK("after_reset", resp(1'b0, 1'b0, st, 16'h0000), rx[31:0])
		$display("Test reset_again done");
		results();
	end
endmodule
